// file: design/hbd_host_port.v
// hbd_host_port.v: host bus front end, local-bus and strobe styles
// assumes all pins synchronous to CLOCK_IN; data pins split into in/out/oe
`timescale 1ns/100ps
`include "hbd_map.vh"

module hbd_host_port (
	input  wire        CLOCK_IN,
	input  wire        SYS_RST_IN,
	input  wire        LOCAL_BUS_STYLE_SELECT_N_IN,
	input  wire [11:0] IO_BASE_IN,
	input  wire [15:1] ADDR_IN,
	input  wire        IO_DECODE_QUALIFIER_IN,
	input  wire [3:0]  BYTE_LANE_SELECT_N_IN,
	input  wire        ADDRESS_LATCH_STROBE_N_IN,
	input  wire        CYCLE_ACTIVE_N_IN,
	input  wire        WRITE_NOT_READ_IN,
	input  wire        ASYNC_READ_STROBE_N_IN,
	input  wire        ASYNC_WRITE_STROBE_N_IN,
	input  wire [31:0] DATA_IN,
	output reg  [31:0] DATA_OUT,
	output wire [31:0] DATA_OE_OUT,
	output wire        LOCAL_DEVICE_CLAIM_N_OUT,
	output wire        ASYNC_READY_OUT,
	output wire        REG_WR_OUT,
	output wire        REG_RD_OUT,
	output reg  [3:0]  REG_LANE_OUT,
	output reg  [3:1]  REG_SEL_OUT,
	output reg  [31:0] REG_WDATA_OUT,
	input  wire [31:0] REG_RDATA_IN,
	input  wire        REG_DONE_IN
);

	localparam ST_IDLE = 2'h0;
	localparam ST_ADDR = 2'h1;
	localparam ST_WAIT = 2'h2;
	localparam ST_HOLD = 2'h3;

	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [15:1] addr_q;
	reg         qual_q;
	reg  [3:0]  be_n_q;
	reg         dir_q;
	reg         rd_en_q;
	reg  [3:0]  rd_lane_q;
	reg         rdy_q;
	reg         rd_s_q;
	reg         wr_s_q;
	reg         done_q;

	wire        vl_mode;
	wire [15:1] addr_cur;
	wire        qual_cur;
	wire [3:0]  be_cur;
	wire        hit;
	wire [3:0]  lane;
	wire        legal;
	wire        strobe_any;
	wire        strobe_lead;

	assign vl_mode = ~LOCAL_BUS_STYLE_SELECT_N_IN;

	// transparent while strobe low, else hold the value caught at its rise
	assign addr_cur = (vl_mode && ADDRESS_LATCH_STROBE_N_IN) ? addr_q : ADDR_IN;
	assign qual_cur = (vl_mode && ADDRESS_LATCH_STROBE_N_IN) ? qual_q : IO_DECODE_QUALIFIER_IN;
	assign be_cur   = (vl_mode && ADDRESS_LATCH_STROBE_N_IN) ? be_n_q : BYTE_LANE_SELECT_N_IN;

	// a15..a4 against base; qualifier high blocks every claim
	assign hit = (addr_cur[`HBD_ADDR_HI:`HBD_ADDR_LO] == IO_BASE_IN) && !qual_cur;
	assign LOCAL_DEVICE_CLAIM_N_OUT = ~hit;

	hbd_lane_decode u_lane (
		.be_n_in   (be_cur),
		.wide_in   (vl_mode),
		.lane_out  (lane),
		.legal_out (legal),
		.size_out  ()
	);

	// strobe pins tied inactive in local-bus style are masked here
	assign strobe_any  = !vl_mode && (!ASYNC_READ_STROBE_N_IN || !ASYNC_WRITE_STROBE_N_IN);
	assign strobe_lead = strobe_any && !(rd_s_q || wr_s_q);

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (vl_mode && !CYCLE_ACTIVE_N_IN && hit && legal)
					state_d = ST_WAIT;
				else if (strobe_lead && hit && legal)
					state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (REG_DONE_IN)
					state_d = ST_HOLD;
			end
			ST_HOLD: begin
				if (vl_mode ? CYCLE_ACTIVE_N_IN : !strobe_any)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			state_q       <= ST_IDLE;
			addr_q        <= 15'h0000;
			qual_q        <= 1'b1;
			be_n_q        <= 4'hf;
			dir_q         <= 1'b0;
			rd_en_q       <= 1'b0;
			rd_lane_q     <= 4'h0;
			rdy_q         <= 1'b1;
			rd_s_q        <= 1'b0;
			wr_s_q        <= 1'b0;
			done_q        <= 1'b0;
			DATA_OUT      <= 32'h00000000;
			REG_LANE_OUT  <= 4'h0;
			REG_SEL_OUT   <= 3'h0;
			REG_WDATA_OUT <= 32'h00000000;
		end else begin
			state_q <= state_d;
			rd_s_q  <= !vl_mode && !ASYNC_READ_STROBE_N_IN;
			wr_s_q  <= !vl_mode && !ASYNC_WRITE_STROBE_N_IN;
			done_q  <= (state_q == ST_WAIT) && REG_DONE_IN;
			if (!ADDRESS_LATCH_STROBE_N_IN) begin
				addr_q <= ADDR_IN;
				qual_q <= IO_DECODE_QUALIFIER_IN;
				be_n_q <= BYTE_LANE_SELECT_N_IN;
			end
			if (state_q == ST_IDLE && state_d == ST_WAIT) begin
				// local bus direction from W/R pin, strobe style from which strobe fell
				dir_q <= vl_mode ? WRITE_NOT_READ_IN : !ASYNC_WRITE_STROBE_N_IN;
				REG_LANE_OUT <= lane;
				// a1 tied low on local bus, upper enables pick the half instead
				REG_SEL_OUT <= vl_mode ? {addr_cur[3:2], 1'b0} : addr_cur[3:1];
				rdy_q <= 1'b0;
			end
			if (state_q == ST_WAIT && REG_DONE_IN) begin
				rdy_q <= 1'b1;
				rd_lane_q <= dir_q ? 4'h0 : REG_LANE_OUT;
				rd_en_q <= !dir_q;
				DATA_OUT <= vl_mode ? REG_RDATA_IN : {16'h0000, REG_RDATA_IN[15:0]};
			end
			if (state_q == ST_HOLD && state_d == ST_IDLE)
				rd_en_q <= 1'b0;
			// write data is latched while the strobe is still low
			if (state_q == ST_WAIT && dir_q)
				REG_WDATA_OUT <= DATA_IN & {{8{REG_LANE_OUT[3]}}, {8{REG_LANE_OUT[2]}},
					{8{REG_LANE_OUT[1]}}, {8{REG_LANE_OUT[0]}}};
		end
	end

	// ready drops combinationally on the strobe edge to avoid a missed wait
	assign ASYNC_READY_OUT = rdy_q && !(strobe_lead && hit && legal);

	// only selected lanes drive, and only for reads
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_oe
			assign DATA_OE_OUT[g*8 +: 8] = {8{rd_en_q && rd_lane_q[g]}};
		end
	endgenerate

	assign REG_WR_OUT = done_q && dir_q;
	assign REG_RD_OUT = (state_q == ST_IDLE) && (state_d == ST_WAIT) && !(vl_mode ?
		WRITE_NOT_READ_IN : !ASYNC_WRITE_STROBE_N_IN);

endmodule

// file: design/hbd_map.vh
// hbd_map.vh: constants for the host bus byte-lane decode block
// assumes inclusion by design files only; definitions, no logic
`ifndef HBD_MAP_VH
`define HBD_MAP_VH

`define HBD_IO_BASE_RST       12'h030
`define HBD_ADDR_HI           15
`define HBD_ADDR_LO           4
`define HBD_REG_SEL_W         3
`define HBD_BE_DWORD          4'h0
`define HBD_BE_LOW_WORD       4'hc
`define HBD_BE_HIGH_WORD      4'h3
`define HBD_BE_BYTE0          4'he
`define HBD_BE_BYTE1          4'hd
`define HBD_BE_BYTE2          4'hb
`define HBD_BE_BYTE3          4'h7
`define HBD_READY_WAIT_CYC    2'h1

`endif

// file: design/hbd_lane_decode.v
// hbd_lane_decode.v: byte-enable pattern to lane select and size decode
// assumes enables already latched or passed by the caller; combinational
`timescale 1ns/100ps
`include "hbd_map.vh"

module hbd_lane_decode (
	input  wire [3:0] be_n_in,
	input  wire       wide_in,
	output reg  [3:0] lane_out,
	output reg        legal_out,
	output reg  [1:0] size_out
);

	always @* begin
		lane_out  = 4'h0;
		legal_out = 1'b1;
		size_out  = 2'h0;
		if (wide_in) begin
			case (be_n_in)
				`HBD_BE_DWORD: begin
					lane_out = 4'hf;
					size_out = 2'h2;
				end
				`HBD_BE_LOW_WORD: begin
					lane_out = 4'h3;
					size_out = 2'h1;
				end
				`HBD_BE_HIGH_WORD: begin
					lane_out = 4'hc;
					size_out = 2'h1;
				end
				`HBD_BE_BYTE0: lane_out = 4'h1;
				`HBD_BE_BYTE1: lane_out = 4'h2;
				`HBD_BE_BYTE2: lane_out = 4'h4;
				`HBD_BE_BYTE3: lane_out = 4'h8;
				default: legal_out = 1'b0;
			endcase
		end else begin
			// upper enables are unused in the narrow style
			lane_out = {2'h0, ~be_n_in[1:0]};
			size_out = (be_n_in[1:0] == 2'h0) ? 2'h1 : 2'h0;
			legal_out = (be_n_in[1:0] != 2'h3);
		end
	end

endmodule

// file: dv/hbd_host_port_props.sv
// hbd_host_port_props.sv: port checks on the host bus front end
// assumes bind onto hbd_host_port
`timescale 1ns/100ps
module hbd_host_port_props (
	input logic        CLOCK_IN, SYS_RST_IN, LOCAL_BUS_STYLE_SELECT_N_IN,
	input logic [11:0] IO_BASE_IN,
	input logic [15:1] ADDR_IN,
	input logic        IO_DECODE_QUALIFIER_IN, ADDRESS_LATCH_STROBE_N_IN,
	input logic        ASYNC_READ_STROBE_N_IN, REG_DONE_IN, REG_RD_OUT,
	input logic [3:0]  BYTE_LANE_SELECT_N_IN, REG_LANE_OUT,
	input logic [31:0] DATA_OE_OUT,
	input logic        LOCAL_DEVICE_CLAIM_N_OUT, ASYNC_READY_OUT,
	input logic [3:1]  REG_SEL_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (SYS_RST_IN);
	wire        sb = LOCAL_BUS_STYLE_SELECT_N_IN;
	wire [3:0]  be = BYTE_LANE_SELECT_N_IN;
	wire [3:0]  ln = REG_LANE_OUT;
	wire [31:0] lm = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
	wire        hit = ADDR_IN[15:4] == IO_BASE_IN && !IO_DECODE_QUALIFIER_IN;
	sequence s_rd_lead;
		$fell(ASYNC_READ_STROBE_N_IN) && sb && hit && be[1:0] != 2'h3;
	endsequence
	sequence s_wait_done;
		!ASYNC_READY_OUT ##1 (!ASYNC_READY_OUT && REG_DONE_IN);
	endsequence
	a_claim_decode: assert property ((sb || !ADDRESS_LATCH_STROBE_N_IN) |->
		LOCAL_DEVICE_CLAIM_N_OUT == !hit) else $error("claim wrong");
	a_qual_ignore: assert property (IO_DECODE_QUALIFIER_IN && sb |-> !REG_RD_OUT)
		else $error("access with qualifier high");
	a_upper_quiet: assert property (sb |-> DATA_OE_OUT[31:16] == 16'h0)
		else $error("upper lanes driven");
	a_oe_lanes: assert property ((DATA_OE_OUT & ~lm) == 32'h0)
		else $error("unselected lane driven");
	a_ready_drop: assert property (s_rd_lead |-> !ASYNC_READY_OUT && REG_RD_OUT)
		else $error("ready not dropped");
	a_ready_rise: assert property (s_wait_done |=> ASYNC_READY_OUT)
		else $error("ready late");
	a_lane_map: assert property (REG_RD_OUT |=> ln ==
		(sb ? {2'h0, ~$past(be[1:0])} : ~$past(be))) else $error("lanes wrong");
	a_sel_addr: assert property (REG_RD_OUT |=> REG_SEL_OUT ==
		(sb ? $past(ADDR_IN[3:1]) : {$past(ADDR_IN[3:2]), 1'b0})) else $error("sel wrong");
endmodule

// file: dv/hbd_core_model.sv
// hbd_core_model.sv: register core answering the front end
// assumes a claimed access is pending while claim is low
`timescale 1ns/100ps
module hbd_core_model (
	input  logic        clk_in, claim_n_in,
	input  logic [3:0]  dly_in,
	output logic        done_out,
	output logic [31:0] rdata_out
);
	logic [3:0] cnt_q = 4'h0;
	always_ff @(posedge clk_in)
		cnt_q <= claim_n_in ? 4'h0 : cnt_q + {3'h0, !done_out};
	assign done_out = cnt_q >= dly_in;
	// no stale data before done
	assign rdata_out = done_out ? 32'h44332211 : 32'hbbccddee;
endmodule

// file: dv/test_hbd_host_port.sv
// test_hbd_host_port.sv: self-checking bench, both bus styles
`timescale 1ns/100ps
module test_hbd_host_port;
	logic        CLOCK_IN = 0, SYS_RST_IN = 1, LOCAL_BUS_STYLE_SELECT_N_IN = 1;
	logic        IO_DECODE_QUALIFIER_IN = 1, ADDRESS_LATCH_STROBE_N_IN = 1;
	logic        CYCLE_ACTIVE_N_IN = 1, WRITE_NOT_READ_IN = 0;
	logic        ASYNC_READ_STROBE_N_IN = 1, ASYNC_WRITE_STROBE_N_IN = 1;
	logic [11:0] IO_BASE_IN = 12'h030;
	logic [15:1] ADDR_IN = 15'h0;
	logic [3:0]  BYTE_LANE_SELECT_N_IN = 4'hf, REG_LANE_OUT, dly = 4'h3;
	logic [31:0] DATA_IN = 32'haabbccdd, DATA_OUT, DATA_OE_OUT, REG_WDATA_OUT, REG_RDATA_IN;
	logic        LOCAL_DEVICE_CLAIM_N_OUT, ASYNC_READY_OUT, REG_WR_OUT, REG_RD_OUT, REG_DONE_IN;
	logic [3:1]  REG_SEL_OUT;
	int          mismatches = 0, tests_run = 0;
	always #10 CLOCK_IN = ~CLOCK_IN;
	hbd_host_port i_hbd_host_port (.*);
	hbd_core_model i_hbd_core_model (.clk_in(CLOCK_IN), .claim_n_in(LOCAL_DEVICE_CLAIM_N_OUT),
		.dly_in(dly), .done_out(REG_DONE_IN), .rdata_out(REG_RDATA_IN));
	function automatic logic [31:0] m(input logic [3:0] b);
		return {{8{~b[3]}}, {8{~b[2]}}, {8{~b[1]}}, {8{~b[0]}}};
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input logic wr);
		int n;
		n = 0;
		while ((wr ? REG_WR_OUT !== 1'b1 : DATA_OE_OUT === 32'h0) && n < 20) begin
			@(posedge CLOCK_IN);
			#1;
			n++;
		end
		if (n == 20) begin
			mismatches++;
			final_report();
		end
	endtask
	task automatic do_reset();
		SYS_RST_IN <= 1'b1;
		repeat (3) @(posedge CLOCK_IN);
		SYS_RST_IN <= 1'b0;
		@(posedge CLOCK_IN);
	endtask
	task automatic rel();
		@(posedge CLOCK_IN);
		ASYNC_READ_STROBE_N_IN <= 1'b1;
		ASYNC_WRITE_STROBE_N_IN <= 1'b1;
		CYCLE_ACTIVE_N_IN <= 1'b1;
		IO_DECODE_QUALIFIER_IN <= 1'b1;
		repeat (2) @(posedge CLOCK_IN);
	endtask
	task automatic isa(input logic [15:0] a, input logic [1:0] be, input logic wr, q);
		@(posedge CLOCK_IN);
		ADDR_IN <= a[15:1];
		BYTE_LANE_SELECT_N_IN <= {2'h3, be};
		IO_DECODE_QUALIFIER_IN <= q;
		@(posedge CLOCK_IN);
		ASYNC_READ_STROBE_N_IN <= wr;
		ASYNC_WRITE_STROBE_N_IN <= !wr;
	endtask
	task automatic vl(input logic [3:0] be, input logic wr);
		@(posedge CLOCK_IN);
		ADDR_IN <= 15'h0184;
		BYTE_LANE_SELECT_N_IN <= be;
		IO_DECODE_QUALIFIER_IN <= 1'b0;
		WRITE_NOT_READ_IN <= wr;
		ADDRESS_LATCH_STROBE_N_IN <= 1'b0;
		@(posedge CLOCK_IN);
		ADDRESS_LATCH_STROBE_N_IN <= 1'b1;
		CYCLE_ACTIVE_N_IN <= 1'b0;
		wt(wr);
	endtask
	task automatic sc_isa();
		for (int i = 0; i < 3; i++) begin
			isa(16'h0306, i[1:0], 1'b0, 1'b0);
			wt(1'b0);
			chk(DATA_OE_OUT, m({2'h3, i[1:0]}));
			// lanes that are not enabled carry no meaning, so only driven lanes are compared
			chk(DATA_OUT & DATA_OE_OUT & {32{ASYNC_READY_OUT}}, 32'h44332211 & m({2'h3, i[1:0]}));
			rel();
		end
		isa(16'h0302, 2'h1, 1'b1, 1'b0);
		wt(1'b1);
		chk(REG_WDATA_OUT, 32'h0000cc00);
		rel();
	endtask
	task automatic sc_refused();
		for (int i = 0; i < 2; i++) begin
			isa(i ? 16'h0406 : 16'h0306, 2'h0, 1'b0, !i);
			repeat (3) @(posedge CLOCK_IN);
			#1;
			chk({LOCAL_DEVICE_CLAIM_N_OUT, ASYNC_READY_OUT, |DATA_OE_OUT}, 3'h6);
			rel();
		end
	endtask
	task automatic sc_vl();
		logic [3:0] pat [7] = '{4'h0, 4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7};
		LOCAL_BUS_STYLE_SELECT_N_IN <= 1'b0;
		do_reset();
		foreach (pat[i]) begin
			vl(pat[i], 1'b0);
			chk(DATA_OUT | ~DATA_OE_OUT, 32'h44332211 | ~m(pat[i]));
			rel();
		end
		vl(4'h0, 1'b1);
		chk(REG_WDATA_OUT, DATA_IN);
		rel();
	endtask
	initial begin
		do_reset();
		sc_isa();
		sc_refused();
		sc_vl();
		final_report();
	end
endmodule
bind hbd_host_port hbd_host_port_props i_props (.*);
